// ### hw/ctu_defs.vh
`ifndef CTU_DEFS_VH
`define CTU_DEFS_VH

// Register byte offsets
`define CTU_OFS_CTRL 8'h00
`define CTU_OFS_FLAGS 8'h04
`define CTU_OFS_STATUS 8'h08
`define CTU_OFS_OPERAND 8'h0c
`define CTU_OFS_SEXT 8'h10
`define CTU_OFS_COND_DATA 8'h14
`define CTU_OFS_COND_STORE 8'h18

// CTRL fields
`define CTU_CTRL_SEL_LSB 0
`define CTU_CTRL_SEL_MSB 3
`define CTU_CTRL_SIZE_LSB 4
`define CTU_CTRL_SIZE_MSB 5
`define CTU_CTRL_STOP_BIT 8

// FLAGS fields
`define CTU_FLAG_C 0
`define CTU_FLAG_V 1
`define CTU_FLAG_Z 2
`define CTU_FLAG_N 3
`define CTU_FLAG_X 4

// STATUS fields
`define CTU_STAT_TRUE 0
`define CTU_STAT_HALTED 1
`define CTU_STAT_BRERR 2
`define CTU_STAT_SKIPPED 3

// Operand sizes
`define CTU_SIZE_BYTE 2'h0
`define CTU_SIZE_WORD 2'h1
`define CTU_SIZE_LONG 2'h2

// Condition selector encodings
`define CTU_SEL_TRUE 4'h0
`define CTU_SEL_FALSE 4'h1
`define CTU_SEL_UNSIGNED_ABOVE 4'h2
`define CTU_SEL_UNSIGNED_AT_MOST 4'h3
`define CTU_SEL_CARRY_CLEAR 4'h4
`define CTU_SEL_CARRY_SET 4'h5
`define CTU_SEL_ZERO_CLEAR 4'h6
`define CTU_SEL_ZERO_SET 4'h7
`define CTU_SEL_OVERFLOW_CLEAR 4'h8
`define CTU_SEL_OVERFLOW_SET 4'h9
`define CTU_SEL_POSITIVE 4'ha
`define CTU_SEL_NEGATIVE 4'hb
`define CTU_SEL_SIGNED_AT_LEAST 4'hc
`define CTU_SEL_SIGNED_BELOW 4'hd
`define CTU_SEL_SIGNED_ABOVE 4'he
`define CTU_SEL_SIGNED_AT_MOST 4'hf

// Reset values
`define CTU_RST_SEL 4'h0
`define CTU_RST_SIZE 2'h2
`define CTU_RST_FLAGS 5'h00
`define CTU_RST_WORD 32'h00000000

// AXI responses
`define CTU_RESP_OKAY 2'h0
`define CTU_RESP_SLVERR 2'h2

`endif

// ### hw/ctu_cond_eval.v
`include "ctu_defs.vh"

module ctu_cond_eval (
    input wire [3:0] sel,
    input wire flag_n,
    input wire flag_z,
    input wire flag_v,
    input wire flag_c,
    output reg cond_true
);

    always @* begin
        case (sel)
            `CTU_SEL_TRUE: cond_true = 1'b1;
            `CTU_SEL_FALSE: cond_true = 1'b0;
            `CTU_SEL_UNSIGNED_ABOVE: cond_true = ~flag_c & ~flag_z;
            `CTU_SEL_UNSIGNED_AT_MOST: cond_true = flag_c | flag_z;
            `CTU_SEL_CARRY_CLEAR: cond_true = ~flag_c;
            `CTU_SEL_CARRY_SET: cond_true = flag_c;
            `CTU_SEL_ZERO_CLEAR: cond_true = ~flag_z;
            `CTU_SEL_ZERO_SET: cond_true = flag_z;
            `CTU_SEL_OVERFLOW_CLEAR: cond_true = ~flag_v;
            `CTU_SEL_OVERFLOW_SET: cond_true = flag_v;
            `CTU_SEL_POSITIVE: cond_true = ~flag_n;
            `CTU_SEL_NEGATIVE: cond_true = flag_n;
            `CTU_SEL_SIGNED_AT_LEAST: cond_true = ~(flag_n ^ flag_v);
            `CTU_SEL_SIGNED_BELOW: cond_true = flag_n ^ flag_v;
            `CTU_SEL_SIGNED_ABOVE: cond_true = ~(flag_n ^ flag_v) & ~flag_z;
            `CTU_SEL_SIGNED_AT_MOST: cond_true = flag_z | (flag_n ^ flag_v);
            default: cond_true = 1'b0;
        endcase
    end

endmodule // ctu_cond_eval

// ### hw/ctu_top.v
// Behaviour
// - Assert true output when the selected test formula on N, Z, V, C yields one.
// - Deassert true output when the formula yields zero; every selector is definite.
// - Selector 0000 always true, selector 0001 always false.
// - 0010 C and Z clear; 0011 C or Z; 0100 C clear; 0101 C set.
// - 0110 true when Z clear; 0111 true when Z set.
// - 1000/1001 overflow clear/set; 1010/1011 negative clear/set, from present flags.
// - 1100 N equals V; 1101 differ; 1110 equal and Z clear; 1111 Z or differ.
// - Sign extension copies the lower portion's top bit into every upper bit.
// - Testing an operand compares it with zero and updates the flags.
// - A false conditional operation without alternative changes only the skipped status bit.
// - Stop halts the processor until an interrupt arrives.
`include "ctu_defs.vh"

module ctu_top #(
    parameter ADDR_WIDTH = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] seq_sel,
    input wire seq_flag_n,
    input wire seq_flag_z,
    input wire seq_flag_v,
    input wire seq_flag_c,
    input wire seq_branch,
    output wire seq_cond_true,
    output wire seq_sel_illegal,
    input wire irq_pin,
    output wire halted
);

    reg [3:0] cond_sel;
    reg [1:0] op_size;
    reg [4:0] flags;
    reg [31:0] operand;
    reg [31:0] cond_data;
    reg halt_state;
    reg branch_err;
    reg store_skipped;
    reg irq_meta;
    reg irq_sync;
    reg aw_have;
    reg w_have;
    reg [ADDR_WIDTH-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] read_word;
    reg read_hit;
    reg write_hit;
    wire reg_cond_true;
    wire wr_fire;
    wire rd_fire;
    wire [7:0] wr_ofs;
    wire [7:0] rd_ofs;
    wire [31:0] sext_value;
    wire [31:0] ctrl_word;
    wire [31:0] status_word;
    wire [31:0] operand_next;
    wire test_zero;
    wire test_neg;
    wire [31:0] tested_value;
    wire stop_req;
    wire brerr_clear;
    wire store_req;

    // Merge new data into an old word under byte enables
    function [31:0] ctu_merge;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0] strb;
        integer i;
        begin
            ctu_merge = old_word;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    ctu_merge[i*8 +: 8] = new_word[i*8 +: 8];
                end
            end
        end
    endfunction

    // Widen the low portion of a value to 32 bits by its sign
    function [31:0] ctu_sext;
        input [31:0] value;
        input [1:0] size;
        begin
            case (size)
                `CTU_SIZE_BYTE: ctu_sext = {{24{value[7]}}, value[7:0]};
                `CTU_SIZE_WORD: ctu_sext = {{16{value[15]}}, value[15:0]};
                default: ctu_sext = value;
            endcase
        end
    endfunction

    // Condition for the sequencer, from its own flag inputs
    // same cycle answer
    ctu_cond_eval u_seq_eval (
        .sel(seq_sel),
        .flag_n(seq_flag_n),
        .flag_z(seq_flag_z),
        .flag_v(seq_flag_v),
        .flag_c(seq_flag_c),
        .cond_true(seq_cond_true)
    );

    // Condition for register-driven operations, from the local flags
    // guards the conditional store
    ctu_cond_eval u_reg_eval (
        .sel(cond_sel),
        .flag_n(flags[`CTU_FLAG_N]),
        .flag_z(flags[`CTU_FLAG_Z]),
        .flag_v(flags[`CTU_FLAG_V]),
        .flag_c(flags[`CTU_FLAG_C]),
        .cond_true(reg_cond_true)
    );

    // flag a branch offered a fixed selector
    assign seq_sel_illegal = seq_branch &
        ((seq_sel == `CTU_SEL_TRUE) | (seq_sel == `CTU_SEL_FALSE));

    assign halted = halt_state;

    // Interrupt pin comes from outside the clock domain
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_meta <= 1'b0;
            irq_sync <= 1'b0;
        end else begin
            irq_meta <= irq_pin;
            irq_sync <= irq_meta;
        end
    end

    // Write channel: address and data taken in either order
    assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
    assign s_axi_wready = ~w_have & ~s_axi_bvalid;
    assign wr_fire = aw_have & w_have & ~s_axi_bvalid;
    assign wr_ofs = {aw_addr[7:2], 2'b00};

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= {ADDR_WIDTH{1'b0}};
            w_data <= `CTU_RST_WORD;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CTU_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= write_hit ? `CTU_RESP_OKAY : `CTU_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @* begin
        case (wr_ofs)
            `CTU_OFS_CTRL: write_hit = 1'b1;
            `CTU_OFS_FLAGS: write_hit = 1'b1;
            `CTU_OFS_STATUS: write_hit = 1'b1;
            `CTU_OFS_OPERAND: write_hit = 1'b1;
            `CTU_OFS_COND_DATA: write_hit = 1'b1;
            `CTU_OFS_COND_STORE: write_hit = 1'b1;
            default: write_hit = 1'b0;
        endcase
    end

    // Operand test results at the selected size
    assign operand_next = ctu_merge(operand, w_data, w_strb);
    // upper bits follow the sign bit
    assign sext_value = ctu_sext(operand, op_size);
    // compare with zero at the selected size
    assign tested_value = ctu_sext(operand_next, op_size);
    assign test_zero = (tested_value == 32'h00000000);
    assign test_neg = tested_value[31];

    // Stop, error clear and guarded store decoded from the write in flight
    assign stop_req = wr_fire && (wr_ofs == `CTU_OFS_CTRL) && w_strb[1]
        && w_data[`CTU_CTRL_STOP_BIT];
    assign brerr_clear = wr_fire && (wr_ofs == `CTU_OFS_STATUS) && w_strb[0]
        && w_data[`CTU_STAT_BRERR];
    assign store_req = wr_fire && (wr_ofs == `CTU_OFS_COND_STORE) && !halt_state;

    // halted from stop until the synchronised interrupt
    // A pending interrupt blocks a new stop
    always @(posedge aclk) begin
        if (!aresetn) begin
            halt_state <= 1'b0;
        end else if (halt_state && irq_sync) begin
            halt_state <= 1'b0;
        end else if (stop_req && !irq_sync) begin
            halt_state <= 1'b1;
        end
    end

    // sticky misuse flag; a new event beats the clear
    // Set from the sequencer port, cleared by writing one
    always @(posedge aclk) begin
        if (!aresetn) begin
            branch_err <= 1'b0;
        end else if (seq_sel_illegal) begin
            branch_err <= 1'b1;
        end else if (brerr_clear) begin
            branch_err <= 1'b0;
        end
    end

    // remember whether the last guarded store was dropped
    always @(posedge aclk) begin
        if (!aresetn) begin
            store_skipped <= 1'b0;
        end else if (store_req) begin
            store_skipped <= ~reg_cond_true;
        end
    end

    // Register state updates
    always @(posedge aclk) begin
        if (!aresetn) begin
            cond_sel <= `CTU_RST_SEL;
            op_size <= `CTU_RST_SIZE;
            flags <= `CTU_RST_FLAGS;
            operand <= `CTU_RST_WORD;
            cond_data <= `CTU_RST_WORD;
        end else begin
            if (wr_fire) begin
                case (wr_ofs)
                    `CTU_OFS_CTRL: begin
                        if (w_strb[0]) begin
                            cond_sel <= w_data[`CTU_CTRL_SEL_MSB:`CTU_CTRL_SEL_LSB];
                            op_size <= w_data[`CTU_CTRL_SIZE_MSB:`CTU_CTRL_SIZE_LSB];
                        end
                    end
                    `CTU_OFS_FLAGS: begin
                        if (w_strb[0]) begin
                            flags <= w_data[4:0];
                        end
                    end
                    `CTU_OFS_OPERAND: begin
                        if (!halt_state) begin
                            operand <= operand_next;
                            flags[`CTU_FLAG_N] <= test_neg;
                            flags[`CTU_FLAG_Z] <= test_zero;
                            flags[`CTU_FLAG_V] <= 1'b0;
                            flags[`CTU_FLAG_C] <= 1'b0;
                        end
                    end
                    `CTU_OFS_COND_DATA: begin
                        if (!halt_state) begin
                            cond_data <= ctu_merge(cond_data, w_data, w_strb);
                        end
                    end
                    `CTU_OFS_COND_STORE: begin
                        if (!halt_state) begin
                            if (reg_cond_true) begin
                                cond_data <= ctu_merge(cond_data, w_data, w_strb);
                            end
                        end
                    end
                    default: begin
                        cond_data <= cond_data;
                    end
                endcase
            end
        end
    end

    // Read channel
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign rd_ofs = {s_axi_araddr[7:2], 2'b00};
    // halted state reads back in CTRL and STATUS
    assign ctrl_word = {23'h000000, halt_state, 2'h0, op_size, cond_sel};
    assign status_word = {28'h0000000, store_skipped, branch_err, halt_state,
        reg_cond_true};

    always @* begin
        read_hit = 1'b1;
        case (rd_ofs)
            `CTU_OFS_CTRL: read_word = ctrl_word;
            `CTU_OFS_FLAGS: read_word = {27'h0000000, flags};
            `CTU_OFS_STATUS: read_word = status_word;
            `CTU_OFS_OPERAND: read_word = operand;
            `CTU_OFS_SEXT: read_word = sext_value;
            `CTU_OFS_COND_DATA: read_word = cond_data;
            `CTU_OFS_COND_STORE: read_word = 32'h00000000;
            default: begin
                read_word = 32'h00000000;
                read_hit = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `CTU_RST_WORD;
            s_axi_rresp <= `CTU_RESP_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_word;
                s_axi_rresp <= read_hit ? `CTU_RESP_OKAY : `CTU_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // ctu_top

// ### sim/ctu_seq_model.sv
module ctu_seq_model (
    input wire logic aclk,
    input wire logic [3:0] req_sel,
    input wire logic [3:0] req_flags,
    input wire logic req_branch,
    input wire logic allow_bad,
    output logic [3:0] seq_sel = 4'h0,
    output logic seq_flag_n = 1'b0,
    output logic seq_flag_z = 1'b0,
    output logic seq_flag_v = 1'b0,
    output logic seq_flag_c = 1'b0,
    output logic seq_branch = 1'b0
);
    always @(posedge aclk) begin
        seq_sel <= req_sel;
        {seq_flag_n, seq_flag_z, seq_flag_v, seq_flag_c} <= req_flags;
        seq_branch <= req_branch && (allow_bad || req_sel > 4'h1);
    end
endmodule // ctu_seq_model

// ### sim/ctu_props.sv
module ctu_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] seq_sel,
    input wire logic seq_flag_n,
    input wire logic seq_flag_z,
    input wire logic seq_flag_v,
    input wire logic seq_flag_c,
    input wire logic seq_branch,
    input wire logic seq_cond_true,
    input wire logic seq_sel_illegal,
    input wire logic irq_pin,
    input wire logic halted
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic n = seq_flag_n;
    wire logic z = seq_flag_z;
    wire logic v = seq_flag_v;
    wire logic c = seq_flag_c;
    AST_ALWAYS: assert property (seq_sel < 4'h2 |-> seq_cond_true == !seq_sel[0])
        else $error("fixed selector result wrong");
    AST_UNSIGNED: assert property (seq_sel inside {[4'h2:4'h5]} |-> seq_cond_true ==
        (seq_sel == 4'h2 ? !(c | z) : seq_sel == 4'h3 ? (c | z) : seq_sel == 4'h4 ? !c : c))
        else $error("unsigned test wrong");
    AST_ZERO: assert property (seq_sel[3:1] == 3'b011 |-> seq_cond_true == (z == seq_sel[0]))
        else $error("zero test wrong");
    AST_SINGLE: assert property (seq_sel[3:2] == 2'b10 |->
        seq_cond_true == ((seq_sel[1] ? n : v) == seq_sel[0])) else $error("single flag test wrong");
    AST_SIGNED: assert property (seq_sel[3:2] == 2'b11 |-> seq_cond_true ==
        (seq_sel[1] ? ((z | (n ^ v)) == seq_sel[0]) : ((n ^ v) == seq_sel[0])))
        else $error("signed test wrong");
    AST_ILLEGAL: assert property (seq_sel_illegal == (seq_branch && seq_sel[3:1] == 3'b000))
        else $error("branch selector flag wrong");
    AST_HALT_WAKE: assert property (irq_pin [*4] |-> !halted)
        else $error("halt not left after interrupt");
    AST_HALT_HOLD: assert property (halted && !irq_pin && !$past(irq_pin) &&
        !$past(irq_pin, 2) |=> halted) else $error("halt left without interrupt");
    cover property (halted ##1 !halted);
    cover property (seq_sel_illegal);
    cover property (seq_sel == 4'hf && seq_cond_true);
endmodule // ctu_props

bind ctu_top ctu_props u_props (.aclk(aclk), .aresetn(aresetn), .seq_sel(seq_sel),
    .seq_flag_n(seq_flag_n), .seq_flag_z(seq_flag_z), .seq_flag_v(seq_flag_v),
    .seq_flag_c(seq_flag_c), .seq_branch(seq_branch), .seq_cond_true(seq_cond_true),
    .seq_sel_illegal(seq_sel_illegal), .irq_pin(irq_pin), .halted(halted));

// ### sim/test_condition_test_unit.sv
`include "ctu_defs.vh"
module test_condition_test_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, irq_pin = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000, q;
    logic [3:0] req_sel = 4'h0, req_flags = 4'h0;
    logic req_branch = 1'b0, allow_bad = 1'b0;
    logic [1:0] r;
    wire awready, wready, bvalid, arready, rvalid, cond_true, sel_illegal, halted;
    wire fn, fz, fv, fc, branch;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] seq_sel;
    int mismatches = 0, checks_done = 0, cycles = 0;
    logic [1:0] sz [6] = '{`CTU_SIZE_BYTE, `CTU_SIZE_BYTE, `CTU_SIZE_BYTE, `CTU_SIZE_WORD,
        `CTU_SIZE_WORD, `CTU_SIZE_LONG};
    logic [31:0] opd [6] = '{32'h00000080, 32'h1234567f, 32'hffffff00, 32'h00008000,
        32'hffff7fff, 32'h80000001};
    logic [31:0] ext [6] = '{32'hffffff80, 32'h0000007f, 32'h00000000, 32'hffff8000,
        32'h00007fff, 32'h80000001};

    always #4 aclk = ~aclk;

    ctu_seq_model u_model (.aclk(aclk), .req_sel(req_sel), .req_flags(req_flags),
        .req_branch(req_branch), .allow_bad(allow_bad), .seq_sel(seq_sel), .seq_flag_n(fn),
        .seq_flag_z(fz), .seq_flag_v(fv), .seq_flag_c(fc), .seq_branch(branch));

    ctu_top #(.ADDR_WIDTH(8)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .seq_sel(seq_sel),
        .seq_flag_n(fn), .seq_flag_z(fz), .seq_flag_v(fv), .seq_flag_c(fc),
        .seq_branch(branch), .seq_cond_true(cond_true), .seq_sel_illegal(sel_illegal),
        .irq_pin(irq_pin), .halted(halted));

    function automatic logic exp_cond(input logic [3:0] s, input logic [3:0] f);
        logic n, z, v, c;
        {n, z, v, c} = f;
        case (s)
            4'h0: return 1'b1;
            4'h1: return 1'b0;
            4'h2: return !c && !z;
            4'h3: return c || z;
            4'h4: return !c;
            4'h5: return c;
            4'h6: return !z;
            4'h7: return z;
            4'h8: return !v;
            4'h9: return v;
            4'ha: return !n;
            4'hb: return n;
            4'hc: return n == v;
            4'hd: return n != v;
            4'he: return n == v && !z;
            default: return z || n != v;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One write or read; handshakes sampled mid-cycle, signals moved after the edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic aw_hit, w_hit, ar_hit, done;
        @(posedge aclk);
        if (wr) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        done = 1'b0;
        while (!done) begin
            @(negedge aclk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            ar_hit = arvalid && arready;
            done = wr ? bvalid : rvalid;
            q = rdata;
            r = wr ? bresp : rresp;
            @(posedge aclk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            if (ar_hit) arvalid <= 1'b0;
            if (done) begin
                bready <= 1'b0;
                rready <= 1'b0;
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        check({30'h0, r}, {30'h0, `CTU_RESP_OKAY});
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h00000000);
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`CTU_OFS_CTRL);
        check(q, 32'h00000020);
        for (int i = 0; i < 256; i++) begin
            @(posedge aclk);
            req_sel <= i[7:4];
            req_flags <= i[3:0];
            @(posedge aclk);
            @(negedge aclk);
            check({31'h0, cond_true}, {31'h0, exp_cond(i[7:4], i[3:0])});
        end
        for (int s = 0; s < 16; s++) begin
            wr(`CTU_OFS_FLAGS, {28'h0, s[3:0] ^ 4'h9});
            wr(`CTU_OFS_CTRL, {26'h0, `CTU_SIZE_LONG, s[3:0]});
            rd(`CTU_OFS_STATUS);
            check({31'h0, q[0]}, {31'h0, exp_cond(s[3:0], s[3:0] ^ 4'h9)});
        end
        for (int b = 0; b < 2; b++) begin
            @(posedge aclk);
            req_sel <= b[3:0];
            req_branch <= 1'b1;
            allow_bad <= 1'b1;
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            check({31'h0, sel_illegal}, 32'h00000001);
            check({31'h0, cond_true}, {31'h0, !b[0]});
            @(posedge aclk);
            allow_bad <= 1'b0;
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            check({31'h0, sel_illegal}, 32'h00000000);
            rd(`CTU_OFS_STATUS);
            check({31'h0, q[2]}, 32'h00000001);
            wr(`CTU_OFS_STATUS, 32'h00000004);
            rd(`CTU_OFS_STATUS);
            check({31'h0, q[2]}, 32'h00000000);
        end
        for (int k = 0; k < 6; k++) begin
            wr(`CTU_OFS_FLAGS, 32'h00000013);
            wr(`CTU_OFS_CTRL, {26'h0, sz[k], 4'h0});
            wr(`CTU_OFS_OPERAND, opd[k]);
            rd(`CTU_OFS_SEXT);
            check(q, ext[k]);
            rd(`CTU_OFS_FLAGS);
            check(q, {27'h0, 1'b1, ext[k][31], ext[k] == 32'h0, 2'b00});
        end
        wr(`CTU_OFS_FLAGS, 32'h00000000);
        wr(`CTU_OFS_CTRL, {26'h0, `CTU_SIZE_LONG, `CTU_SEL_ZERO_SET});
        wr(`CTU_OFS_COND_DATA, 32'h11111111);
        wr(`CTU_OFS_COND_STORE, 32'haaaaaaaa);
        rd(`CTU_OFS_COND_DATA);
        check(q, 32'h11111111);
        rd(`CTU_OFS_FLAGS);
        check(q, 32'h00000000);
        rd(`CTU_OFS_STATUS);
        check({31'h0, q[3]}, 32'h00000001);
        wr(`CTU_OFS_CTRL, {26'h0, `CTU_SIZE_LONG, `CTU_SEL_ZERO_CLEAR});
        wr(`CTU_OFS_COND_STORE, 32'haaaaaaaa);
        rd(`CTU_OFS_COND_DATA);
        check(q, 32'haaaaaaaa);
        rd(`CTU_OFS_STATUS);
        check({31'h0, q[3]}, 32'h00000000);
        wr(`CTU_OFS_CTRL, 32'h00000120);
        @(negedge aclk);
        check({31'h0, halted}, 32'h00000001);
        rd(`CTU_OFS_CTRL);
        check({31'h0, q[8]}, 32'h00000001);
        wr(`CTU_OFS_COND_DATA, 32'h00000055);
        rd(`CTU_OFS_COND_DATA);
        check(q, 32'haaaaaaaa);
        rd(`CTU_OFS_STATUS);
        check({31'h0, q[1]}, 32'h00000001);
        @(posedge aclk);
        irq_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        check({31'h0, halted}, 32'h00000000);
        @(posedge aclk);
        irq_pin <= 1'b0;
        xfer(1'b1, 8'h1c, 32'h00000001);
        check({30'h0, r}, {30'h0, `CTU_RESP_SLVERR});
        rd(8'h1c);
        check({q[29:0], r}, {30'h0, `CTU_RESP_SLVERR});
        end_sim();
    end
endmodule // test_condition_test_unit
